/* uie_defines.vh */
// Register offsets, field positions and reset values of the channel interrupt logic.
`ifndef UIE_DEFINES_VH
`define UIE_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets on APB
// ----------------------------------------------------------------------
`define UIE_OFS_MASK      8'h00
`define UIE_OFS_FIFO      8'h04
`define UIE_OFS_EXT       8'h08
`define UIE_OFS_TRIG      8'h0c
`define UIE_OFS_LINE      8'h10
`define UIE_OFS_MODEM     8'h14
`define UIE_OFS_SOURCE    8'h18
`define UIE_OFS_THOLD     8'h1c

// ----------------------------------------------------------------------
// Interrupt mask bit positions
// ----------------------------------------------------------------------
`define UIE_MB_RX         0
`define UIE_MB_THR        1
`define UIE_MB_LINE       2
`define UIE_MB_MODEM      3
`define UIE_MB_SLEEP      4
`define UIE_MB_XOFF       5
`define UIE_MB_RTS        6
`define UIE_MB_CTS        7

// ----------------------------------------------------------------------
// Other field positions and reset values
// ----------------------------------------------------------------------
`define UIE_FIFO_EN_BIT   0
`define UIE_EXT_EN_BIT    4
`define UIE_SRC_RXST_BIT  4
`define UIE_LS_READY      0
`define UIE_LS_ERR_LO     1
`define UIE_LS_ERR_HI     4
`define UIE_LS_TX_EMPTY   5
`define UIE_LS_TX_IDLE    6
`define UIE_LS_FIFO_ERR   7
`define UIE_RST_BYTE      8'h00
`define UIE_RST_TRIG      8'h01
`define UIE_ZERO_WORD     32'h0000_0000
`define UIE_ZERO_FILL     8'h00

// ----------------------------------------------------------------------
// Priority level codes shown in the interrupt source register
// ----------------------------------------------------------------------
`define UIE_LVL_NONE      4'h0
`define UIE_LVL_LINE      4'h1
`define UIE_LVL_RX        4'h2
`define UIE_LVL_THR       4'h3
`define UIE_LVL_MODEM     4'h4
`define UIE_LVL_XOFF      4'h5
`define UIE_LVL_FLOW      4'h6

`endif

/* uie_top.v */
// Channel interrupt masking, source and line state logic with an APB slave.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "uie_defines.vh"

// Overview of operation
// - CTS pin rising edge interrupts when enabled
// - RTS pin rising edge interrupts when enabled
// - Received Xoff interrupts only when enabled
// - Sleep bit enables or disables sleep mode
// - Any modem change bit interrupts when enabled
// - Any receive error or break interrupts
// - Transmit interrupt follows holding empty or FIFO empty
// - Non-FIFO receive interrupt while holding has data
// - FIFO receive interrupt at and above trigger
// - Receive reported level 2, transmit level 3
// - Source receive status follows trigger level
// - Data ready set on load, cleared empty
// - Transmit empty cleared by source read or holding write
// - Low mask bits zero in FIFO mode means no interrupts
// - Line error field shows error type or break
// - Transmit empty bit set when FIFO empty
// - Idle bit needs FIFO and shifter empty
// - Top line bit shows FIFO data error
// - Mask gates sources onto channel interrupt pin
// - Mask register resets to all zero
// - FIFO enable bit selects FIFO mode
// - Upper mask bits writable only when extended
module uie_top
(
  input  wire        clock_in,          // 125 MHz device clock.
  input  wire        resetn_in,         // Synchronous reset, active low.
  input  wire        psel_in,           // APB select.
  input  wire        penable_in,        // APB access phase.
  input  wire        pwrite_in,         // APB direction, high for write.
  input  wire [7:0]  paddr_in,          // APB byte address.
  input  wire [31:0] pwdata_in,         // APB write data.
  output reg  [31:0] prdata_out,        // APB read data.
  output reg         pready_out,        // APB ready.
  output reg         pslverr_out,       // APB error on unmapped address.
  input  wire [7:0]  rx_fill_in,        // Characters in the receive FIFO.
  input  wire [7:0]  tx_fill_in,        // Characters in the transmit FIFO.
  input  wire        tx_shift_empty_in, // Transmit shifter holds nothing.
  input  wire [3:0]  rx_error_in,       // Overrun, parity, framing, break.
  input  wire        rx_fifo_error_in,  // Some queued character has an error.
  input  wire [3:0]  modem_delta_in,    // Modem change bits.
  input  wire        xoff_seen_in,      // Pulse: an Xoff character arrived.
  input  wire        rts_n_in,          // Level driven onto the RTS pin.
  input  wire        cts_n_pin_in,      // CTS pin, asynchronous.
  output reg         irq_out,           // Channel interrupt, active high.
  output reg         sleep_en_out,      // Sleep mode enable.
  output reg         fifo_en_out,       // FIFO mode selected.
  output reg         tx_load_out,       // Pulse: write to transmit holding.
  output reg  [7:0]  tx_data_out        // Byte written to transmit holding.
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Rising edge of a level given its present and previous sample.
  function rise;
    input now_v;
    input was_v;
    begin
      rise = now_v & ~was_v;
    end
  endfunction

  // Sticky flag update where a new event beats a clear in the same cycle.
  function sticky;
    input flag_v;
    input set_v;
    input clr_v;
    begin
      sticky = set_v | (flag_v & ~clr_v);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg  [7:0] interrupt_mask;
  reg  [7:0] fifo_setup;
  reg  [7:0] extended_features;
  reg  [7:0] rx_trigger;
  reg        cts_meta;
  reg        cts_sync;
  reg        cts_prev;
  reg        rts_prev;
  reg        tx_empty_prev;
  reg        thr_flag;
  reg        xoff_flag;
  reg        rts_flag;
  reg        cts_flag;
  reg  [7:0] line_state;
  reg  [7:0] interrupt_source;
  reg  [7:0] next_line_state;
  reg  [7:0] next_source;
  reg  [7:0] pending;
  reg  [31:0] next_rdata;
  reg        next_err;

  wire       access_ph;
  wire       wr_take;
  wire       rd_take;
  wire       hit_mask;
  wire       hit_fifo;
  wire       hit_ext;
  wire       hit_trig;
  wire       hit_line;
  wire       hit_modem;
  wire       hit_source;
  wire       hit_thold;
  wire       mapped;
  wire       fifo_mode;
  wire       tx_empty;
  wire       rx_at_trig;
  wire       rx_ready;
  wire       thr_clear;
  wire       src_read;
  wire       polled;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------

  // The slave answers in the second access cycle; pready_out drops the
  // cycle after so a held request is never taken twice.
  assign access_ph  = psel_in & penable_in & ~pready_out;
  assign wr_take    = access_ph & pwrite_in;
  assign rd_take    = access_ph & ~pwrite_in;
  assign hit_mask   = (paddr_in == `UIE_OFS_MASK);
  assign hit_fifo   = (paddr_in == `UIE_OFS_FIFO);
  assign hit_ext    = (paddr_in == `UIE_OFS_EXT);
  assign hit_trig   = (paddr_in == `UIE_OFS_TRIG);
  assign hit_line   = (paddr_in == `UIE_OFS_LINE);
  assign hit_modem  = (paddr_in == `UIE_OFS_MODEM);
  assign hit_source = (paddr_in == `UIE_OFS_SOURCE);
  assign hit_thold  = (paddr_in == `UIE_OFS_THOLD);
  assign mapped     = hit_mask | hit_fifo | hit_ext | hit_trig | hit_line |
                      hit_modem | hit_source | hit_thold;

  // Side effects of reads and writes that clear the transmit interrupt.
  assign src_read   = rd_take & hit_source;
  assign thr_clear  = src_read | (wr_take & hit_thold);

  // ----------------------------------------------------------------------
  // Source conditions
  // ----------------------------------------------------------------------
  assign fifo_mode  = fifo_setup[`UIE_FIFO_EN_BIT];
  // FIFO polled operation: with no low source enabled the pin stays quiet.
  assign polled     = fifo_mode & ~|interrupt_mask[`UIE_MB_MODEM:`UIE_MB_RX];
  assign tx_empty   = (tx_fill_in == `UIE_ZERO_FILL);
  assign rx_at_trig = (rx_fill_in >= rx_trigger);
  // In single holding register mode one character is already enough.
  assign rx_ready   = fifo_mode ? rx_at_trig :
                      (rx_fill_in != `UIE_ZERO_FILL);

  // ----------------------------------------------------------------------
  // Pin synchroniser and edge history
  // ----------------------------------------------------------------------

  // The CTS pin is asynchronous; only cts_sync is looked at by logic.
  always @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      cts_meta      <= 1'b0;
      cts_sync      <= 1'b0;
      cts_prev      <= 1'b0;
      rts_prev      <= 1'b0;
      tx_empty_prev <= 1'b0;
    end
    else
    begin
      cts_meta      <= cts_n_pin_in;
      cts_sync      <= cts_meta;
      cts_prev      <= cts_sync;
      rts_prev      <= rts_n_in;
      tx_empty_prev <= tx_empty;
    end
  end

  // ----------------------------------------------------------------------
  // Sticky event flags
  // ----------------------------------------------------------------------

  // Events are always caught; the mask only decides whether they reach
  // the pin, so enabling a source later shows an earlier event.
  always @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      thr_flag  <= 1'b0;
      xoff_flag <= 1'b0;
      rts_flag  <= 1'b0;
      cts_flag  <= 1'b0;
    end
    else
    begin
      thr_flag  <= sticky(thr_flag, rise(tx_empty, tx_empty_prev), thr_clear);
      xoff_flag <= sticky(xoff_flag, xoff_seen_in, src_read);
      rts_flag  <= sticky(rts_flag, rise(rts_n_in, rts_prev), src_read);
      cts_flag  <= sticky(cts_flag, rise(cts_sync, cts_prev), src_read);
    end
  end

  // ----------------------------------------------------------------------
  // Pending sources, line state and source register
  // ----------------------------------------------------------------------

  // Pending bits sit at the mask bit of their source.
  always @*
  begin
    pending                 = `UIE_RST_BYTE;
    pending[`UIE_MB_RX]     = rx_ready;
    pending[`UIE_MB_THR]    = tx_empty & thr_flag;
    pending[`UIE_MB_LINE]   = |rx_error_in;
    pending[`UIE_MB_MODEM]  = |modem_delta_in;
    pending[`UIE_MB_XOFF]   = xoff_flag;
    pending[`UIE_MB_RTS]    = rts_flag;
    pending[`UIE_MB_CTS]    = cts_flag;
  end

  // Line state bits for polled operation.
  always @*
  begin
    next_line_state                                = `UIE_RST_BYTE;
    next_line_state[`UIE_LS_READY]                 = (rx_fill_in != `UIE_ZERO_FILL);
    next_line_state[`UIE_LS_ERR_HI:`UIE_LS_ERR_LO] = rx_error_in;
    next_line_state[`UIE_LS_TX_EMPTY]              = tx_empty;
    next_line_state[`UIE_LS_TX_IDLE]               = tx_empty & tx_shift_empty_in;
    next_line_state[`UIE_LS_FIFO_ERR]              = rx_fifo_error_in;
  end

  // Highest priority enabled source, plus the FIFO receive indication.
  always @*
  begin
    next_source = `UIE_RST_BYTE;
    if (pending[`UIE_MB_LINE] & interrupt_mask[`UIE_MB_LINE])
      next_source[3:0] = `UIE_LVL_LINE;
    else if (pending[`UIE_MB_RX] & interrupt_mask[`UIE_MB_RX])
      next_source[3:0] = `UIE_LVL_RX;
    else if (pending[`UIE_MB_THR] & interrupt_mask[`UIE_MB_THR])
      next_source[3:0] = `UIE_LVL_THR;
    else if (pending[`UIE_MB_MODEM] & interrupt_mask[`UIE_MB_MODEM])
      next_source[3:0] = `UIE_LVL_MODEM;
    else if (pending[`UIE_MB_XOFF] & interrupt_mask[`UIE_MB_XOFF])
      next_source[3:0] = `UIE_LVL_XOFF;
    else if (|(pending[`UIE_MB_CTS:`UIE_MB_RTS] &
               interrupt_mask[`UIE_MB_CTS:`UIE_MB_RTS]))
      next_source[3:0] = `UIE_LVL_FLOW;
    next_source[`UIE_SRC_RXST_BIT] = fifo_mode & rx_at_trig &
                                     interrupt_mask[`UIE_MB_RX];
  end

  always @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      line_state       <= `UIE_RST_BYTE;
      interrupt_source <= `UIE_RST_BYTE;
    end
    else
    begin
      line_state       <= next_line_state;
      interrupt_source <= next_source;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt and mode outputs
  // ----------------------------------------------------------------------

  // The sleep bit is not a source and is kept out of the gate. With the
  // four low bits clear in FIFO mode the pin stays low, even for enabled
  // flow events, and the host polls line state instead.
  always @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      irq_out      <= 1'b0;
      sleep_en_out <= 1'b0;
      fifo_en_out  <= 1'b0;
    end
    else
    begin
      irq_out      <= |(pending & interrupt_mask) & ~polled;
      sleep_en_out <= interrupt_mask[`UIE_MB_SLEEP];
      fifo_en_out  <= fifo_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------

  // The upper mask nibble keeps its value unless extended features are on.
  always @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      interrupt_mask    <= `UIE_RST_BYTE;
      fifo_setup        <= `UIE_RST_BYTE;
      extended_features <= `UIE_RST_BYTE;
      rx_trigger        <= `UIE_RST_TRIG;
      tx_load_out       <= 1'b0;
      tx_data_out       <= `UIE_RST_BYTE;
    end
    else
    begin
      tx_load_out <= wr_take & hit_thold;
      if (wr_take & hit_mask)
      begin
        interrupt_mask[`UIE_MB_MODEM:`UIE_MB_RX] <= pwdata_in[`UIE_MB_MODEM:`UIE_MB_RX];
        if (extended_features[`UIE_EXT_EN_BIT])
          interrupt_mask[`UIE_MB_CTS:`UIE_MB_SLEEP] <=
            pwdata_in[`UIE_MB_CTS:`UIE_MB_SLEEP];
      end
      if (wr_take & hit_fifo)
        fifo_setup <= pwdata_in[7:0];
      if (wr_take & hit_ext)
        extended_features <= pwdata_in[7:0];
      if (wr_take & hit_trig)
        rx_trigger <= pwdata_in[7:0];
      if (wr_take & hit_thold)
        tx_data_out <= pwdata_in[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------

  // Transmit holding reads as zero; the data lives in the transmit FIFO.
  always @*
  begin
    next_rdata = `UIE_ZERO_WORD;
    next_err   = ~mapped;
    if (hit_mask)
      next_rdata[7:0] = interrupt_mask;
    else if (hit_fifo)
      next_rdata[7:0] = fifo_setup;
    else if (hit_ext)
      next_rdata[7:0] = extended_features;
    else if (hit_trig)
      next_rdata[7:0] = rx_trigger;
    else if (hit_line)
      next_rdata[7:0] = line_state;
    else if (hit_modem)
      next_rdata[3:0] = modem_delta_in;
    else if (hit_source)
      next_rdata[7:0] = interrupt_source;
  end

  // ----------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------

  // Read data stays at zero outside a read answer to keep the bus quiet.
  always @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= `UIE_ZERO_WORD;
    end
    else
    begin
      pready_out  <= access_ph;
      pslverr_out <= access_ph & next_err;
      prdata_out  <= rd_take ? next_rdata : `UIE_ZERO_WORD;
    end
  end

endmodule // uie_top

/* uie_checker.sv */
// Concurrent assertions on the ports of the channel interrupt logic.
`timescale 1ns/1ps
module uie_checker
(
  input wire        clock_in,       // Device clock.
  input wire        resetn_in,      // Synchronous reset, active low.
  input wire        psel_in,        // APB select.
  input wire        penable_in,     // APB access phase.
  input wire        pwrite_in,      // APB direction.
  input wire [7:0]  paddr_in,       // APB byte address.
  input wire [31:0] pwdata_in,      // APB write data.
  input wire        pready_out,     // APB ready.
  input wire [7:0]  rx_fill_in,     // Receive FIFO count.
  input wire [3:0]  rx_error_in,    // Receive error levels.
  input wire [3:0]  modem_delta_in, // Modem change bits.
  input wire        irq_out,        // Channel interrupt.
  input wire        sleep_en_out,   // Sleep enable.
  input wire        fifo_en_out,    // FIFO mode.
  input wire        tx_load_out     // Holding write pulse.
);
  logic [7:0] msk; // Mask shadow, one cycle behind the design.
  logic       ext; // Extended enable shadow.
  logic       done;
  logic       mwr;
  logic       fwr;

  // Completed writes and writes in any phase seen on the bus.
  assign done = psel_in && penable_in && pwrite_in && pready_out;
  assign mwr = psel_in && pwrite_in && paddr_in == 8'h00;
  assign fwr = psel_in && pwrite_in && paddr_in == 8'h04;

  // The shadow lags the design, so rules below need three quiet samples.
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      msk <= 8'h00;
      ext <= 1'b0;
    end
    else if (done && paddr_in == 8'h00)
      msk <= {ext ? pwdata_in[7:4] : msk[7:4], pwdata_in[3:0]};
    else if (done && paddr_in == 8'h08)
      ext <= pwdata_in[4];
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  property p_rst_clear; $rose(resetn_in) |-> !irq_out && !sleep_en_out; endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("Outputs not clear after reset.");
  property p_sleep_src; $changed(sleep_en_out) |-> $past(mwr) || $past(mwr, 2); endproperty
  a_sleep_src: assert property (p_sleep_src)
    else $error("Sleep enable moved without a mask write.");
  property p_fifo_src; $changed(fifo_en_out) |-> $past(fwr) || $past(fwr, 2); endproperty
  a_fifo_src: assert property (p_fifo_src)
    else $error("FIFO mode moved without a setup write.");
  property p_line_irq; (msk[2] && rx_error_in != 4'h0)[*3] |-> irq_out; endproperty
  a_line_irq: assert property (p_line_irq)
    else $error("Line error did not interrupt.");
  property p_modem_irq; (msk[3] && modem_delta_in != 4'h0)[*3] |-> irq_out; endproperty
  a_modem_irq: assert property (p_modem_irq)
    else $error("Modem change did not interrupt.");
  property p_rx_irq; (!fifo_en_out && msk[0] && rx_fill_in != 8'h00)[*3] |-> irq_out; endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("Held receive data did not interrupt.");
  property p_polled; (fifo_en_out && msk[3:0] == 4'h0)[*3] |-> !irq_out; endproperty
  a_polled: assert property (p_polled)
    else $error("Interrupt raised in polled mode.");
  property p_tx_load; done && paddr_in == 8'h1c |-> tx_load_out; endproperty
  a_tx_load: assert property (p_tx_load)
    else $error("Holding write gave no load pulse.");
  property p_ready; psel_in && penable_in && !pready_out |=> pready_out; endproperty
  a_ready: assert property (p_ready)
    else $error("Access phase not answered in time.");
endmodule // uie_checker

bind uie_top uie_checker i_uie_checker (.clock_in(clock_in), .resetn_in(resetn_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pready_out(pready_out), .rx_fill_in(rx_fill_in),
  .rx_error_in(rx_error_in), .modem_delta_in(modem_delta_in), .irq_out(irq_out),
  .sleep_en_out(sleep_en_out), .fifo_en_out(fifo_en_out), .tx_load_out(tx_load_out));

/* uie_host_model.sv */
// APB host that stands on the register side of the channel interrupt logic.
`timescale 1ns/1ps
module uie_host_model
(
  input  wire        clock_in,    // Device clock.
  output logic       psel_out,    // APB select.
  output logic       penable_out, // APB access phase.
  output logic       pwrite_out,  // APB direction.
  output logic [7:0] paddr_out,   // APB byte address.
  output logic [31:0] pwdata_out, // APB write data.
  input  wire [31:0] prdata_in,   // APB read data.
  input  wire        pready_in,   // APB ready.
  input  wire        pslverr_in   // APB error.
);
  initial
  begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0000_0000;
  end

  // One transfer; it waits a clock first so a strobe is never set twice at one edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge clock_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clock_in);
    penable_out <= 1'b1;
    do @(posedge clock_in); while (pready_in !== 1'b1);
    rd = prdata_in;
    er = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule // uie_host_model

/* uart_interrupt_enable_logic_tb_top.sv */
// Self-checking testbench for the channel interrupt logic.
`timescale 1ns/1ps
module uart_interrupt_enable_logic_tb_top;
  logic        clock_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [7:0]  rx_fill = 8'h00, tx_fill = 8'h00;
  logic [3:0]  rx_err = 4'h0, mdelta = 4'h0;
  logic        shift_e = 1'b0, fe = 1'b0, xoff = 1'b0, rts_n = 1'b0, cts_n = 1'b0;
  wire         psel, penable, pwrite, pready, pslverr, irq, sleep, fifo_en, tx_load;
  wire  [7:0]  paddr, tx_data;
  wire  [31:0] pwdata, prdata;
  logic [31:0] rdat;
  logic        err;
  logic [7:0]  e;
  int          error_cnt = 0, checks = 0, cyc = 0;

  uie_host_model i_uie_host_model (.clock_in(clock_in), .psel_out(psel),
    .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
    .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));
  uie_top i_uie_top (.clock_in(clock_in), .resetn_in(resetn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .rx_fill_in(rx_fill),
    .tx_fill_in(tx_fill), .tx_shift_empty_in(shift_e), .rx_error_in(rx_err),
    .rx_fifo_error_in(fe), .modem_delta_in(mdelta), .xoff_seen_in(xoff), .rts_n_in(rts_n),
    .cts_n_pin_in(cts_n), .irq_out(irq), .sleep_en_out(sleep), .fifo_en_out(fifo_en),
    .tx_load_out(tx_load), .tx_data_out(tx_data));

  // 125 MHz clock; a hang is cut short well past the expected run length.
  always #4 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_uie_host_model.xfer(1'b1, a, d, rdat, err);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    i_uie_host_model.xfer(1'b0, a, 32'h0, rdat, err);
    chk("read data", x, rdat);
  endtask

  // Lets registered outputs catch up, including the two-flop CTS path.
  task automatic irqc(input logic x);
    repeat (6) @(posedge clock_in);
    chk("irq", {31'h0, x}, {31'h0, irq});
  endtask

  // Main sequence: reset, access rules, every source, then the sticky events.
  initial
  begin
    repeat (16) @(posedge clock_in);
    resetn_in <= 1'b1;
    rdc(8'h00, 32'h0);
    rdc(8'h0c, 32'h1);
    i_uie_host_model.xfer(1'b0, 8'h20, 32'h0, rdat, err);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("sleep", 32'h0, {31'h0, sleep});
    wr(8'h00, 32'hff);
    rdc(8'h00, 32'h0f);
    wr(8'h08, 32'h10);
    wr(8'h00, 32'h10);
    irqc(1'b0);
    chk("sleep", 32'h1, {31'h0, sleep});
    wr(8'h00, 32'h04);
    @(posedge clock_in);
    chk("sleep", 32'h0, {31'h0, sleep});
    for (int i = 0; i < 8; i++)
    begin
      rx_fill <= {7'h0, i[0]};
      tx_fill <= i[1] ? 8'h03 : 8'h00;
      shift_e <= i[2];
      fe <= i[0];
      rx_err <= 4'h1 << i[1:0];
      e = {i[0], !i[1] && i[2], !i[1], 4'h1 << i[1:0], i[0]};
      rdc(8'h10, {24'h0, e});
      irqc(1'b1);
    end
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h20);
    xoff <= 1'b1;
    @(posedge clock_in);
    xoff <= 1'b0;
    irqc(1'b0);
    chk("fifo mode", 32'h1, {31'h0, fifo_en});
    rx_err <= 4'h0;
    fe <= 1'b0;
    wr(8'h00, 32'h08);
    for (int i = 0; i < 4; i++)
    begin
      mdelta <= 4'h1 << i;
      irqc(1'b1);
      rdc(8'h14, {28'h0, 4'h1 << i});
    end
    mdelta <= 4'h0;
    irqc(1'b0);
    wr(8'h0c, 32'h4);
    wr(8'h00, 32'h1);
    rx_fill <= 8'h03;
    irqc(1'b0);
    rdc(8'h18, 32'h0);
    rx_fill <= 8'h04;
    irqc(1'b1);
    rdc(8'h18, 32'h12);
    rx_fill <= 8'h03;
    irqc(1'b0);
    rdc(8'h18, 32'h0);
    wr(8'h04, 32'h0);
    rx_fill <= 8'h00;
    irqc(1'b0);
    rx_fill <= 8'h01;
    irqc(1'b1);
    rdc(8'h18, 32'h2);
    rx_fill <= 8'h00;
    wr(8'h00, 32'h02);
    tx_fill <= 8'h00;
    irqc(1'b1);
    rdc(8'h18, 32'h3);
    irqc(1'b0);
    tx_fill <= 8'h01;
    irqc(1'b0);
    tx_fill <= 8'h00;
    irqc(1'b1);
    wr(8'h1c, 32'h5a);
    irqc(1'b0);
    chk("tx data", 32'h5a, {24'h0, tx_data});
    wr(8'h00, 32'h00);
    xoff <= 1'b1;
    @(posedge clock_in);
    xoff <= 1'b0;
    irqc(1'b0);
    rdc(8'h18, 32'h0);
    wr(8'h00, 32'h20);
    xoff <= 1'b1;
    @(posedge clock_in);
    xoff <= 1'b0;
    irqc(1'b1);
    rdc(8'h18, 32'h5);
    irqc(1'b0);
    wr(8'h00, 32'h40);
    rts_n <= 1'b1;
    irqc(1'b1);
    rdc(8'h18, 32'h6);
    rts_n <= 1'b0;
    irqc(1'b0);
    wr(8'h00, 32'h80);
    cts_n <= 1'b1;
    irqc(1'b1);
    rdc(8'h18, 32'h6);
    irqc(1'b0);
    test_done();
  end
endmodule // uart_interrupt_enable_logic_tb_top
